//--- src/btf_monitor.sv
`timescale 1ns/1ps
// ballast trigger sequencer with fault latch, preheat timer and register port
module btf_monitor
    import btf_pkg::*;
#(
    parameter logic [BTF_PER_W-1:0] PERIOD_CYC = BTF_PER_W'(BTF_TRIG_PERIOD_CYC),
    parameter logic [BTF_SEC_W-1:0] SECOND_CYC = BTF_SEC_W'(BTF_SECOND_CYC),
    parameter logic [BTF_OSC_W-1:0] MIN_OSC    = BTF_OSC_W'(BTF_MIN_OSC)
) (
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    input  wire logic                  clk_en,
    input  wire logic                  supply_above_trig,
    input  wire logic                  supply_above_reset,
    input  wire logic                  supply_above_low,
    input  wire logic                  fault_sense_input,
    input  wire logic                  over_temp,
    input  wire logic                  temp_mode_select,
    input  wire logic                  lamp_swap_input,
    input  wire logic                  trigger_kill_pin_in,
    output wire logic                  trigger_kill_pin_out,
    output wire logic                  trigger_kill_pin_oe,
    output wire logic                  preheat_n,
    output wire logic                  irq,
    input  wire logic [BTF_ADDR_W-1:0] addr,
    input  wire logic [BTF_DATA_W-1:0] wdata,
    input  wire logic                  wr,
    input  wire logic                  rd,
    output wire logic [BTF_DATA_W-1:0] rdata
);

    btf_state_t st_reg;
    btf_state_t st_next;

    logic [BTF_IN_W-1:0] raw_in;
    logic                sup7;
    logic                sup8;
    logic                fault_now;
    logic                otemp;
    logic                tmode;
    logic                per_tick;
    logic                rise8;
    logic                fell6;
    logic                lamp_rise;
    logic                osc_rise;
    logic                block;
    logic                trig_ok;

    localparam btf_state_t ST_RESET = '{
        sync1:       '0,
        sync2:       '0,
        sync3:       '0,
        filt:        '0,
        filt_d:      '0,
        per_cnt:     '0,
        pul_cnt:     '0,
        osc_cnt:     '0,
        dly_cnt:     '0,
        pre_cnt:     '0,
        flt:         FLT_IDLE,
        running:     1'b0,
        fault_latch: 1'b0,
        temp_block:  1'b0,
        kill_cut:    1'b0,
        dropout:     1'b0,
        preheat_n:   1'b1,
        trk_out:     1'b0,
        trk_oe:      1'b0,
        ctl:         BTF_CTL_RESET,
        ev_status:   '0,
        ev_enable:   BTF_EN_RESET,
        irq:         1'b0,
        rdata:       '0
    };

    function automatic logic rose_at(
        input logic [BTF_IN_W-1:0] cur,
        input logic [BTF_IN_W-1:0] prev,
        input int unsigned         lane
    );
        rose_at = cur[lane] & ~prev[lane];
    endfunction: rose_at

    assign raw_in[BTF_IN_SUP7]  = supply_above_trig;
    assign raw_in[BTF_IN_SUP8]  = supply_above_reset;
    assign raw_in[BTF_IN_SUP6]  = supply_above_low;
    assign raw_in[BTF_IN_FAULT] = fault_sense_input;
    assign raw_in[BTF_IN_OSC]   = trigger_kill_pin_in;
    assign raw_in[BTF_IN_TEMP]  = over_temp;
    assign raw_in[BTF_IN_TMODE] = temp_mode_select;
    assign raw_in[BTF_IN_LAMP]  = lamp_swap_input;

    // R18 act on filtered indications only
    assign sup7      = st_reg.filt[BTF_IN_SUP7];
    assign sup8      = st_reg.filt[BTF_IN_SUP8];
    assign fault_now = st_reg.filt[BTF_IN_FAULT];
    assign otemp     = st_reg.filt[BTF_IN_TEMP];
    assign tmode     = st_reg.filt[BTF_IN_TMODE];
    assign rise8     = rose_at(st_reg.filt, st_reg.filt_d, BTF_IN_SUP8);
    assign lamp_rise = rose_at(st_reg.filt, st_reg.filt_d, BTF_IN_LAMP);
    assign fell6     = rose_at(st_reg.filt_d, st_reg.filt, BTF_IN_SUP6);
    // our own pulse on the pin must not count as oscillation
    assign osc_rise  = rose_at(st_reg.filt, st_reg.filt_d, BTF_IN_OSC) & ~st_reg.trk_oe;
    assign per_tick  = sup7 && (st_reg.per_cnt == PERIOD_CYC - 1'b1);
    assign block     = st_reg.fault_latch | st_reg.temp_block;
    assign trig_ok   = per_tick && !st_reg.running && !block
                       && st_reg.ctl[BTF_CTL_TRIG_EN];

    always_comb begin
        logic [BTF_IN_W-1:0] agree;
        logic [BTF_EV_W-1:0] ev;
        logic [BTF_EV_W-1:0] clr;
        agree = ~(st_reg.sync2 ^ st_reg.sync3);
        ev = '0;
        clr = '0;
        st_next = st_reg;

        // R18 three stages, change taken once stages two and three agree
        st_next.sync1  = raw_in;
        st_next.sync2  = st_reg.sync1;
        st_next.sync3  = st_reg.sync2;
        st_next.filt   = (st_reg.sync3 & agree) | (st_reg.filt & ~agree);
        st_next.filt_d = st_reg.filt;

        // R1 period timer runs only above the trigger threshold
        if (!sup7 || per_tick) begin
            st_next.per_cnt = '0;
        end else begin
            st_next.per_cnt = st_reg.per_cnt + 1'b1;
        end

        // R1 pulse start and width
        if (st_reg.trk_out) begin
            // R12 a block cuts a pulse short
            if (block || st_reg.pul_cnt == '0) begin
                st_next.trk_out = 1'b0;
            end else begin
                st_next.pul_cnt = st_reg.pul_cnt - 1'b1;
            end
        end else if (trig_ok) begin
            st_next.trk_out = 1'b1;
            st_next.pul_cnt = BTF_PULSE_LAST;
        end

        // R2 count oscillations per period
        if (!sup8) begin
            // R5 no supervision below the reset threshold
            st_next.osc_cnt = '0;
            st_next.running = 1'b0;
        end else if (per_tick) begin
            st_next.running = (st_reg.osc_cnt >= MIN_OSC);
            st_next.osc_cnt = '0;
            if (!st_reg.running && st_reg.osc_cnt >= MIN_OSC) begin
                ev[BTF_EV_OSC] = 1'b1;
            end
        end else if (osc_rise && st_reg.osc_cnt != '1) begin
            st_next.osc_cnt = st_reg.osc_cnt + 1'b1;
        end

        // R6 R7 fault sampled once per period
        if (sup8) begin
            case (st_reg.flt)
                FLT_IDLE: begin
                    if (per_tick && fault_now) begin
                        // R8 first error starts the delay
                        st_next.flt     = FLT_DELAY;
                        st_next.dly_cnt = SECOND_CYC - 1'b1;
                        ev[BTF_EV_ERR1] = 1'b1;
                    end
                end
                FLT_DELAY: begin
                    if (st_reg.dly_cnt == '0) begin
                        st_next.flt = FLT_RECHECK;
                    end else begin
                        st_next.dly_cnt = st_reg.dly_cnt - 1'b1;
                    end
                end
                FLT_RECHECK: begin
                    if (per_tick) begin
                        if (fault_now) begin
                            // R9 second error latches
                            st_next.flt         = FLT_LATCHED;
                            st_next.fault_latch = 1'b1;
                            ev[BTF_EV_LATCH]    = 1'b1;
                        end else begin
                            // R10 no second error
                            st_next.flt = FLT_IDLE;
                        end
                    end
                end
                FLT_LATCHED: begin
                    if (!st_reg.fault_latch) begin
                        st_next.flt = FLT_IDLE;
                    end
                end
                default: begin
                    st_next.flt = FLT_IDLE;
                end
            endcase
        end

        // R5 R14 over-temperature supervision
        if (sup8) begin
            if (otemp) begin
                st_next.temp_block = 1'b1;
                if (!st_reg.temp_block) begin
                    ev[BTF_EV_TEMP] = 1'b1;
                end
            end else if (st_reg.temp_block && !tmode) begin
                // R15 R16 mode low restarts once the indication drops
                st_next.temp_block = 1'b0;
            end
        end

        // R13 supply collapse under block removes the drive until the block clears
        if (!block) begin
            st_next.kill_cut = 1'b0;
        end else if (fell6) begin
            st_next.kill_cut = 1'b1;
        end

        // R11 a dip below the low threshold not caused by our drive
        if (!st_reg.filt[BTF_IN_SUP6] && !st_reg.kill_cut && !st_reg.trk_oe) begin
            st_next.dropout = 1'b1;
        end

        // R4 preheat timer
        if (!st_reg.preheat_n) begin
            if (st_reg.pre_cnt == '0) begin
                st_next.preheat_n   = 1'b1;
                ev[BTF_EV_PREHEAT]  = 1'b1;
            end else begin
                st_next.pre_cnt = st_reg.pre_cnt - 1'b1;
            end
        end

        // R11 R17 lamp change clears the latch and restarts triggering
        if (lamp_rise) begin
            st_next.fault_latch = 1'b0;
            st_next.flt         = FLT_IDLE;
            st_next.running     = 1'b0;
            st_next.osc_cnt     = '0;
            st_next.per_cnt     = '0;
            ev[BTF_EV_LAMP]     = 1'b1;
        end

        // R3 reset threshold reached: reset units, start preheat
        if (rise8) begin
            st_next.flt       = FLT_IDLE;
            st_next.running   = 1'b0;
            st_next.osc_cnt   = '0;
            st_next.per_cnt   = '0;
            st_next.trk_out   = 1'b0;
            st_next.preheat_n = 1'b0;
            st_next.pre_cnt   = SECOND_CYC - 1'b1;
            st_next.dropout   = 1'b0;
            // R11 R15 latches survive our own collapse, not a mains loss
            if (st_reg.dropout) begin
                st_next.fault_latch = 1'b0;
                st_next.temp_block  = 1'b0;
            end
        end

        // R12 R14 pin drive: pulse high, turn-off transistor low
        st_next.trk_oe = st_next.trk_out
                         | ((st_next.fault_latch | st_next.temp_block) & ~st_next.kill_cut);

        // register writes
        if (wr) begin
            if (addr == BTF_REG_CLEAR) begin
                clr = wdata[BTF_EV_W-1:0];
            end else if (addr == BTF_REG_ENABLE) begin
                st_next.ev_enable = wdata[BTF_EV_W-1:0];
            end else if (addr == BTF_REG_CTRL) begin
                st_next.ctl = wdata[BTF_CTL_W-1:0];
            end
        end

        // a new event wins over a clear in the same cycle
        st_next.ev_status = (st_reg.ev_status & ~clr) | ev;
        st_next.irq       = |(st_next.ev_status & st_next.ev_enable);

        // register reads, data valid for the following cycle only
        st_next.rdata = '0;
        if (rd) begin
            if (addr == BTF_REG_STATUS) begin
                st_next.rdata = {{(BTF_DATA_W-BTF_EV_W){1'b0}}, st_reg.ev_status};
            end else if (addr == BTF_REG_ENABLE) begin
                st_next.rdata = {{(BTF_DATA_W-BTF_EV_W){1'b0}}, st_reg.ev_enable};
            end else if (addr == BTF_REG_CTRL) begin
                st_next.rdata = {{(BTF_DATA_W-BTF_CTL_W){1'b0}}, st_reg.ctl};
            end else if (addr == BTF_REG_STATE) begin
                st_next.rdata = {{(BTF_DATA_W-10){1'b0}}, st_reg.flt,
                                 ~st_reg.preheat_n, st_reg.kill_cut,
                                 st_reg.temp_block, st_reg.fault_latch,
                                 st_reg.running, sup8, sup7, st_reg.trk_out};
            end
        end
    end

    // clock enable low freezes everything, strobes included
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= ST_RESET;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign trigger_kill_pin_out = st_reg.trk_out;
    assign trigger_kill_pin_oe  = st_reg.trk_oe;
    assign preheat_n            = st_reg.preheat_n;
    assign irq                  = st_reg.irq;
    assign rdata                = st_reg.rdata;

    property p_trig_fire;
        @(posedge clock) disable iff (!rst_n)
        clk_en && trig_ok && !st_reg.trk_out && !rise8 |=> trigger_kill_pin_out
            && trigger_kill_pin_oe;
    endproperty
    a_trig_fire: assert property (p_trig_fire) else $error("trigger did not fire"); // R1

    property p_no_trig_running;
        @(posedge clock) disable iff (!rst_n)
        clk_en && st_reg.running |=> !$rose(trigger_kill_pin_out);
    endproperty
    a_no_trig_running: assert property (p_no_trig_running) else $error("pulse while running"); // R2

    property p_preheat_start;
        @(posedge clock) disable iff (!rst_n)
        clk_en && rise8 |=> !preheat_n ##0 st_reg.pre_cnt == SECOND_CYC - 1'b1;
    endproperty
    a_preheat_start: assert property (p_preheat_start) else $error("preheat not started"); // R3

    property p_preheat_end;
        @(posedge clock) disable iff (!rst_n)
        clk_en && !preheat_n && st_reg.pre_cnt == '0 && !rise8 |=> preheat_n;
    endproperty
    a_preheat_end: assert property (p_preheat_end) else $error("preheat not released"); // R4

    property p_delay_load;
        @(posedge clock) disable iff (!rst_n)
        clk_en && sup8 && per_tick && fault_now && st_reg.flt == FLT_IDLE
            && !rise8 && !lamp_rise |=> st_reg.flt == FLT_DELAY
            && st_reg.dly_cnt == SECOND_CYC - 1'b1;
    endproperty
    a_delay_load: assert property (p_delay_load) else $error("delay not started"); // R8

    property p_latch_cause;
        @(posedge clock) disable iff (!rst_n)
        $rose(st_reg.fault_latch) |-> $past(st_reg.flt) == FLT_RECHECK && $past(fault_now);
    endproperty
    a_latch_cause: assert property (p_latch_cause) else $error("latch without second error"); // R9

    property p_recheck_clean;
        @(posedge clock) disable iff (!rst_n)
        clk_en && sup8 && st_reg.flt == FLT_RECHECK && per_tick && !fault_now
            |=> st_reg.flt == FLT_IDLE && !st_reg.fault_latch;
    endproperty
    a_recheck_clean: assert property (p_recheck_clean) else $error("first error kept"); // R10

    property p_lamp_clear;
        @(posedge clock) disable iff (!rst_n)
        clk_en && lamp_rise |=> !st_reg.fault_latch;
    endproperty
    a_lamp_clear: assert property (p_lamp_clear) else $error("lamp change kept latch"); // R11

    property p_kill_drive;
        @(posedge clock) disable iff (!rst_n)
        clk_en && (st_reg.fault_latch || (st_reg.temp_block && (otemp || tmode || !sup8)))
            && !st_reg.kill_cut && !fell6 && !lamp_rise && !rise8
            |=> trigger_kill_pin_oe && !trigger_kill_pin_out;
    endproperty
    a_kill_drive: assert property (p_kill_drive) else $error("no turn-off drive"); // R12

    property p_kill_cut;
        @(posedge clock) disable iff (!rst_n)
        clk_en && st_reg.fault_latch && fell6 && !lamp_rise && !rise8
            |=> !trigger_kill_pin_oe [*2];
    endproperty
    a_kill_cut: assert property (p_kill_cut) else $error("drive kept after collapse"); // R13

    property p_temp_auto;
        @(posedge clock) disable iff (!rst_n)
        clk_en && sup8 && st_reg.temp_block && !otemp && !tmode |=> !st_reg.temp_block;
    endproperty
    a_temp_auto: assert property (p_temp_auto) else $error("no automatic restart"); // R16

endmodule: btf_monitor

//--- src/btf_pkg.sv
// constants and types for the ballast trigger and fault monitor
// How it works
// R1 - above the trigger threshold, fire trigger pulses once every 960 us period
// R2 - enough oscillations counted in one period marks running and stops triggers
// R3 - reset threshold rising resets all logic units and starts the preheat timer; the code keeps fault_latch and temp_block unless dropout is set
// R4 - preheat output is active low and stays active for one second
// R5 - temperature and oscillation supervision act only above the reset threshold
// R6 - fault comparator high counts as an error
// R7 - fault comparator is sampled once per trigger period
// R8 - first error starts a one second delay, then the comparator is checked again
// R9 - fault latch sets only on a second error in the cycle after the delay
// R10 - no error at the recheck drops the first error and resumes sampling
// R11 - fault latch clears on brief supply removal or a lamp change
// R12 - latched fault blocks triggers and drives the turn-off transistor
// R13 - below the low threshold with a fault, drive stops but triggers stay blocked
// R14 - over-temperature blocks triggers and drives the turn-off transistor too
// R15 - temperature mode picks automatic restart or restart after mains loss
// R16 - temperature mode low restarts automatically once the part has cooled
// R17 - a lamp change restarts the trigger sequence
// R18 - logic acts only on synchronised digital supply indications
package btf_pkg;

    localparam int unsigned BTF_CLK_MHZ         = 125;
    localparam int unsigned BTF_TRIG_PERIOD_US  = 960;
    localparam int unsigned BTF_TRIG_PERIOD_CYC = BTF_TRIG_PERIOD_US * BTF_CLK_MHZ;
    localparam int unsigned BTF_ONE_SECOND_MS   = 1000;
    localparam int unsigned BTF_SECOND_CYC      = BTF_ONE_SECOND_MS * 1000 * BTF_CLK_MHZ;
    localparam int unsigned BTF_PULSE_NS        = 900;
    localparam int unsigned BTF_PULSE_CYC       = (BTF_PULSE_NS * BTF_CLK_MHZ + 999) / 1000;
    localparam int unsigned BTF_MIN_OSC         = 4;

    localparam int unsigned BTF_PER_W  = 17;
    localparam int unsigned BTF_SEC_W  = 27;
    localparam int unsigned BTF_PUL_W  = 7;
    localparam int unsigned BTF_OSC_W  = 4;
    localparam int unsigned BTF_ADDR_W = 8;
    localparam int unsigned BTF_DATA_W = 32;

    localparam logic [BTF_PUL_W-1:0] BTF_PULSE_LAST = BTF_PUL_W'(BTF_PULSE_CYC - 1);

    // synchroniser lanes
    localparam int unsigned BTF_IN_W     = 8;
    localparam int unsigned BTF_IN_SUP7  = 0;
    localparam int unsigned BTF_IN_SUP8  = 1;
    localparam int unsigned BTF_IN_SUP6  = 2;
    localparam int unsigned BTF_IN_FAULT = 3;
    localparam int unsigned BTF_IN_OSC   = 4;
    localparam int unsigned BTF_IN_TEMP  = 5;
    localparam int unsigned BTF_IN_TMODE = 6;
    localparam int unsigned BTF_IN_LAMP  = 7;

    // event bits of status, clear and enable
    localparam int unsigned BTF_EV_W       = 6;
    localparam int unsigned BTF_EV_OSC     = 0;
    localparam int unsigned BTF_EV_ERR1    = 1;
    localparam int unsigned BTF_EV_LATCH   = 2;
    localparam int unsigned BTF_EV_TEMP    = 3;
    localparam int unsigned BTF_EV_LAMP    = 4;
    localparam int unsigned BTF_EV_PREHEAT = 5;

    localparam logic [BTF_ADDR_W-1:0] BTF_REG_STATUS = 8'h00;
    localparam logic [BTF_ADDR_W-1:0] BTF_REG_CLEAR  = 8'h04;
    localparam logic [BTF_ADDR_W-1:0] BTF_REG_ENABLE = 8'h08;
    localparam logic [BTF_ADDR_W-1:0] BTF_REG_CTRL   = 8'h0C;
    localparam logic [BTF_ADDR_W-1:0] BTF_REG_STATE  = 8'h10;

    localparam int unsigned BTF_CTL_W       = 1;
    localparam int unsigned BTF_CTL_TRIG_EN = 0;
    localparam logic [BTF_CTL_W-1:0] BTF_CTL_RESET = 1'h1;
    localparam logic [BTF_EV_W-1:0]  BTF_EN_RESET  = 6'h00;

    typedef enum logic [1:0] {
        FLT_IDLE,
        FLT_DELAY,
        FLT_RECHECK,
        FLT_LATCHED
    } btf_fault_st_t;

    typedef struct packed {
        logic [BTF_IN_W-1:0]   sync1;
        logic [BTF_IN_W-1:0]   sync2;
        logic [BTF_IN_W-1:0]   sync3;
        logic [BTF_IN_W-1:0]   filt;
        logic [BTF_IN_W-1:0]   filt_d;
        logic [BTF_PER_W-1:0]  per_cnt;
        logic [BTF_PUL_W-1:0]  pul_cnt;
        logic [BTF_OSC_W-1:0]  osc_cnt;
        logic [BTF_SEC_W-1:0]  dly_cnt;
        logic [BTF_SEC_W-1:0]  pre_cnt;
        btf_fault_st_t         flt;
        logic                  running;
        logic                  fault_latch;
        logic                  temp_block;
        logic                  kill_cut;
        logic                  dropout;
        logic                  preheat_n;
        logic                  trk_out;
        logic                  trk_oe;
        logic [BTF_CTL_W-1:0]  ctl;
        logic [BTF_EV_W-1:0]   ev_status;
        logic [BTF_EV_W-1:0]   ev_enable;
        logic                  irq;
        logic [BTF_DATA_W-1:0] rdata;
    } btf_state_t;

endpackage: btf_pkg

//--- tb/btf_ballast_model.sv
`timescale 1ns/1ps
// ballast oscillator tank and lamp network as seen from the trigger/kill pin
module btf_ballast_model (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic start_ok,
    input  wire logic pin_out,
    input  wire logic pin_oe,
    output wire logic pin_level
);
    logic       osc_reg;
    logic [1:0] div_reg;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            osc_reg <= 1'b0;
            div_reg <= 2'h0;
        end else begin
            div_reg <= div_reg + 2'h1;
            // the tank only starts when the bench lets a pulse succeed
            if (pin_oe && pin_out && start_ok) begin
                osc_reg <= 1'b1;
            end else if (pin_oe && !pin_out) begin
                osc_reg <= 1'b0;
            end
        end
    end
    // undriven pin follows the tank, toggling every two clocks while it oscillates, low through the lamp network when stopped
    assign pin_level = pin_oe ? pin_out : (osc_reg & div_reg[1]);
endmodule: btf_ballast_model

//--- tb/testbench.sv
`timescale 1ns/1ps
// self-checking bench for the ballast trigger and fault monitor
module testbench;
    import btf_pkg::*;
    localparam int PER = 400;
    localparam int SEC = 200;
    logic clock = 0, rst_n = 0, sup7 = 0, sup8 = 0, sup6 = 0, fault = 0, hot = 0, lamp = 0;
    logic start_ok = 0, wr = 0, rd = 0, pin_in, pin_out, pin_oe, preheat_n, irq;
    logic ce = 1, tmode = 0;
    logic [BTF_ADDR_W-1:0] addr = '0;
    logic [BTF_DATA_W-1:0] wdata = '0, rdata, d, e;
    int n_errors = 0, comparisons = 0, seed = 32'h0b47, n, n2;
    always #4 clock = ~clock;
    btf_monitor #(.PERIOD_CYC(17'(PER)), .SECOND_CYC(27'(SEC))) btf_monitor_inst (
        .clock(clock), .rst_n(rst_n), .clk_en(ce), .supply_above_trig(sup7),
        .supply_above_reset(sup8), .supply_above_low(sup6), .fault_sense_input(fault),
        .over_temp(hot), .temp_mode_select(tmode), .lamp_swap_input(lamp),
        .trigger_kill_pin_in(pin_in), .trigger_kill_pin_out(pin_out),
        .trigger_kill_pin_oe(pin_oe), .preheat_n(preheat_n), .irq(irq), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    btf_ballast_model btf_ballast_model_inst (.clock(clock), .rst_n(rst_n),
        .start_ok(start_ok), .pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_in));
    task automatic test_done();
        $display("checks %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask: test_done
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask: check
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        wr <= 1'b1; addr <= a; wdata <= v;
        @(posedge clock);
        wr <= 1'b0;
    endtask: wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock);
        rd <= 1'b1; addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1 v = rdata;
    endtask: rd_reg
    // bounded wait for a given drive state of the pin
    task automatic wait_pin(input logic oe_v, input logic out_v, input int lim);
        int i;
        i = 0;
        while (!(pin_oe === oe_v && (pin_out === out_v || !oe_v)) && i < lim) begin
            @(posedge clock);
            #1 i++;
        end
        if (i >= lim) begin
            n_errors++;
            $display("mismatch pin_drive expected %b%b seen timeout", oe_v, out_v);
            test_done();
        end
    endtask: wait_pin
    task automatic count_pin(input logic oe_v, output int c);
        c = 0;
        while (pin_oe === oe_v && c < 5000) begin
            @(posedge clock);
            #1 c++;
        end
    endtask: count_pin
    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        #1 check("pin_oe", pin_oe, 0);
        check("preheat_n", preheat_n, 1);
        rd_reg(BTF_REG_ENABLE, d);
        check("enable", d, 0);
        rd_reg(BTF_REG_CTRL, d);
        check("ctrl", d, 1);
        rd_reg(8'h20, d);
        check("unmapped", d, 0);
        e = 32'($random(seed)) & 32'h0000_003f;
        wr_reg(BTF_REG_ENABLE, e);
        rd_reg(BTF_REG_ENABLE, d);
        check("enable_rw", d, e);
        wr_reg(BTF_REG_ENABLE, 32'h0000_0000);
        // clock enable low: the write strobe is lost
        ce <= 1'b0;
        wr_reg(BTF_REG_ENABLE, 32'h0000_0001);
        ce <= 1'b1;
        rd_reg(BTF_REG_ENABLE, d);
        check("frozen_wr", d, 0);
        $display("test registers done");
        @(posedge clock);
        sup7 <= 1'b1; sup8 <= 1'b1; sup6 <= 1'b1;
        n = 0;
        while (preheat_n !== 1'b0 && n < 50) begin
            @(posedge clock);
            #1 n++;
        end
        n = 0;
        while (preheat_n === 1'b0 && n < 5000) begin
            @(posedge clock);
            #1 n++;
        end
        check("preheat_len", n, SEC);
        $display("test preheat done");
        wait_pin(1'b1, 1'b1, 2 * PER);
        count_pin(1'b1, n);
        check("pulse_len", n, BTF_PULSE_CYC);
        count_pin(1'b0, n2);
        check("trig_period", n + n2, PER);
        $display("test trigger done");
        start_ok <= 1'b1;
        repeat (3 * PER) @(posedge clock);
        n = 0;
        repeat (3 * PER) begin
            @(posedge clock);
            #1 n += int'(pin_oe === 1'b1);
        end
        check("no_trig_running", n, 0);
        rd_reg(BTF_REG_STATE, d);
        check("running", d[3], 1);
        $display("test oscillation done");
        // a single error followed by a clean recheck must not latch
        // drop the error soon after it is registered, so the recheck is clean
        wr_reg(BTF_REG_ENABLE, 32'h0000_0002);
        fault <= 1'b1;
        n = 0;
        while (irq !== 1'b1 && n < 2 * PER) begin
            @(posedge clock);
            #1 n++;
        end
        check("err1_irq", irq, 1);
        repeat ($random(seed) & 32'h3f) @(posedge clock);
        fault <= 1'b0;
        repeat (3 * PER) @(posedge clock);
        rd_reg(BTF_REG_STATUS, d);
        check("first_error", d[BTF_EV_ERR1], 1);
        rd_reg(BTF_REG_STATE, d);
        check("no_latch", d[4], 0);
        $display("test single error done");
        wr_reg(BTF_REG_ENABLE, 32'h0000_0004);
        fault <= 1'b1;
        wait_pin(1'b1, 1'b0, 2 * PER + SEC + 100);
        repeat (3) @(posedge clock);
        #1 check("irq_latch", irq, 1);
        rd_reg(BTF_REG_STATE, d);
        check("latched", d[4], 1);
        wr_reg(BTF_REG_CLEAR, 32'h0000_003f);
        @(posedge clock);
        #1 check("irq_cleared", irq, 0);
        sup6 <= 1'b0;
        wait_pin(1'b0, 1'b0, 50);
        count_pin(1'b0, n);
        check("blocked_low", n, 5000);
        sup6 <= 1'b1;
        $display("test fault latch done");
        fault <= 1'b0; start_ok <= 1'b0; lamp <= 1'b1;
        wait_pin(1'b1, 1'b1, 2 * PER + 50);
        check("lamp_restart", pin_out, 1);
        $display("test lamp change done");
        start_ok <= 1'b1;
        repeat (3 * PER) @(posedge clock);
        hot <= 1'b1;
        wait_pin(1'b1, 1'b0, 50);
        check("temp_kill", pin_out, 0);
        hot <= 1'b0; start_ok <= 1'b0;
        wait_pin(1'b1, 1'b1, 2 * PER + 50);
        check("temp_restart", pin_out, 1);
        $display("test over temperature done");
        start_ok <= 1'b1; tmode <= 1'b1;
        repeat (3 * PER) @(posedge clock);
        hot <= 1'b1;
        wait_pin(1'b1, 1'b0, 50);
        hot <= 1'b0;
        count_pin(1'b1, n);
        check("temp_hold", n, 5000);
        // mains loss: rst_n pulsed low while the supply indications stay high, then a fresh start
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        #1 check("pin_oe_rst", pin_oe, 0);
        wait_pin(1'b1, 1'b1, 2 * PER + 50);
        check("mains_restart", pin_out, 1);
        $display("test temperature mode done");
        test_done();
    end
endmodule: testbench
